// ==== hdl/efh_axis.sv ====
// Per-axis encoder feedback, homing and absolute serial readout
// Overview of operation
// - Quadrature inputs are sampled on the fast encoder clock so count rates up to 16 MHz are tracked.
// - Each edge of one phase alone moves the position by one, up or down by phase order; a change of both phases at once is not counted.
// - Encoder feedback exists on the axis, is always used in servo mode and optional for steppers.
// - A stepper with encoder compares encoder and commanded position and flags a correction after the move.
// - Servo, encoder stepper and absolute feedback offer slip or stall detection and geared encoder tracking; open-loop stepping has no stall detection.
// - Switch homing loads the position counter with a preset when the switch goes active.
// - After the home event the axis is told to ramp down or stop at once, as configured.
// - Homing direction, switch active level and stop response are set per axis.
// - Encoder homing needs index, active switch and the selected quadrant all at once.
// - The default home pattern is phase A high, phase B low, index and switch active.
// - The phase levels of the home pattern are programmable and either phase may be ignored.
// - An absolute encoder gets a differential serial clock and answers with data on phase A.
// - The serial clock runs at 31,250 Hz times a power of two, up to 4 MHz.
// - Serial words are up to 12 bits as standard and up to 32 bits with the wide option.
// - Encoders with equal rate and width can share one serial clock.
module efh_axis
    import efh_pkg::*;
(
    input logic clk,
    input logic resetn,
    input logic enc_clk,
    input efh_enc_pins_t enc_pins,
    input efh_fb_mode_t fb_mode,
    input logic select_absolute_feedback_command,
    input efh_home_cfg_t home_cfg,
    input logic encoder_home_pattern_command,
    input efh_home_pat_t home_pattern,
    input logic home_arm,
    input logic [POS_W-1:0] commanded_pos,
    input logic move_done,
    input logic [STALL_W-1:0] stall_limit,
    input logic track_enable,
    input logic signed [GEAR_W-1:0] gear_num,
    input logic [GSH_W-1:0] gear_shift,
    input efh_ssi_cfg_t absolute_encoder_config_command,
    input logic read_encoder_command,
    input logic ssi_data_in,
    output logic ssi_clk_out,
    output logic ssi_clk_out_n,
    output logic [POS_W-1:0] position_r,
    output logic position_valid_r,
    output logic [POS_W-1:0] fb_position_r,
    output logic signed [POS_W-1:0] position_error_r,
    output logic correction_req_r,
    output logic stall_r,
    output logic [POS_W-1:0] track_target_r,
    output logic homing_dir_r,
    output logic home_found_r,
    output logic stop_decel_r,
    output logic stop_now_r,
    output logic ssi_busy
);
    function automatic logic [CNT_W-1:0] ssi_period(input logic [SEL_W-1:0] sel);
        return CNT_W'(SYS_CLK_HZ / (SSI_BASE_HZ << sel));
    endfunction : ssi_period

    function automatic logic [BITS_W-1:0] ssi_width(
        input logic [BITS_W-1:0] bits, input logic wide);
        logic [BITS_W-1:0] lim;
        lim = wide ? BITS_W'(SSI_MAX_BITS) : BITS_W'(SSI_STD_BITS);
        if (bits == '0) return BITS_W'(1);
        return (bits > lim) ? lim : bits;
    endfunction : ssi_width

    // Encoder clock domain
    logic enc_rst_s1_r, enc_rst_n_r;
    efh_enc_pins_t pin_s1_r, pin_s2_r, pin_p_r;
    efh_enc_cfg_t cfg_s1_r, ecfg_r, enc_cfg;
    logic req_tog_r, req_s1_r, req_s2_r, ack_tog_r, home_tog_r;
    logic fired_r, home_cond_p_r;
    logic [POS_W-1:0] pos_r, pos_hold_r;
    logic a_chg, b_chg, quad_up, quad_dn, sw_act, pat_ok, home_cond, home_load;

    always_ff @(posedge enc_clk) begin
        enc_rst_s1_r <= resetn;
        enc_rst_n_r <= enc_rst_s1_r;
    end

    always_ff @(posedge enc_clk) begin
        if (!enc_rst_n_r) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_p_r <= '0;
            cfg_s1_r <= '0;
            ecfg_r <= '0;
        end else begin
            pin_s1_r <= enc_pins;
            pin_s2_r <= pin_s1_r;
            pin_p_r <= pin_s2_r;
            cfg_s1_r <= enc_cfg;
            ecfg_r <= cfg_s1_r;
        end
    end

    assign a_chg = pin_s2_r.a ^ pin_p_r.a;
    assign b_chg = pin_s2_r.b ^ pin_p_r.b;
    assign quad_up = (a_chg ^ b_chg) & (pin_s2_r.a ^ pin_p_r.b);
    assign quad_dn = (a_chg ^ b_chg) & ~(pin_s2_r.a ^ pin_p_r.b);
    assign sw_act = ~(pin_s2_r.home_sw ^ ecfg_r.sw_active_high);
    assign pat_ok = (~ecfg_r.pat.care_a | (pin_s2_r.a == ecfg_r.pat.req_a))
        & (~ecfg_r.pat.care_b | (pin_s2_r.b == ecfg_r.pat.req_b));

    always_comb begin
        home_cond = 1'b0;
        if (ecfg_r.mode == HM_SWITCH) begin
            home_cond = sw_act;
        end else if (ecfg_r.mode == ENCODER_HOMING_MODE) begin
            home_cond = pin_s2_r.index & sw_act & pat_ok;
        end
    end

    assign home_load = ecfg_r.armed & ~fired_r & home_cond & ~home_cond_p_r;

    always_ff @(posedge enc_clk) begin
        if (!enc_rst_n_r) begin
            fired_r <= 1'b0;
            home_cond_p_r <= 1'b0;
            home_tog_r <= 1'b0;
        end else begin
            home_cond_p_r <= home_cond;
            if (!ecfg_r.armed) begin
                fired_r <= 1'b0;
            end else if (home_load) begin
                fired_r <= 1'b1;
                home_tog_r <= ~home_tog_r;
            end
        end
    end

    always_ff @(posedge enc_clk) begin
        if (!enc_rst_n_r) begin
            pos_r <= '0;
        end else if (home_load) begin
            pos_r <= ecfg_r.preset;
        end else if (quad_up) begin
            pos_r <= pos_r + POS_W'(1);
        end else if (quad_dn) begin
            pos_r <= pos_r - POS_W'(1);
        end
    end

    // Snapshot handshake toward the system clock
    always_ff @(posedge enc_clk) begin
        if (!enc_rst_n_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            ack_tog_r <= 1'b0;
            pos_hold_r <= '0;
        end else begin
            req_s1_r <= req_tog_r;
            req_s2_r <= req_s1_r;
            if (req_s2_r != ack_tog_r) begin
                pos_hold_r <= pos_r;
                ack_tog_r <= req_s2_r;
            end
        end
    end

    // System clock domain
    logic ack_s1_r, ack_s2_r;
    logic hm_s1_r, hm_s2_r, hm_s3_r, home_evt, armed_r;
    logic [POS_W-1:0] enc_pos_r, ssi_word_r;
    efh_home_pat_t pat_r;
    logic signed [POS_W-1:0] err;
    logic [POS_W-1:0] err_mag;
    logic signed [POS_W+GEAR_W-1:0] track_prod;

    assign enc_cfg = '{mode: home_cfg.mode, sw_active_high:
        home_cfg.sw_active_high, pat: pat_r, armed: armed_r,
        preset: home_cfg.preset};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            req_tog_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            enc_pos_r <= '0;
        end else begin
            ack_s1_r <= ack_tog_r;
            ack_s2_r <= ack_s1_r;
            if (ack_s2_r == req_tog_r) begin
                enc_pos_r <= pos_hold_r;
                req_tog_r <= ~req_tog_r;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            hm_s1_r <= 1'b0;
            hm_s2_r <= 1'b0;
            hm_s3_r <= 1'b0;
        end else begin
            hm_s1_r <= home_tog_r;
            hm_s2_r <= hm_s1_r;
            hm_s3_r <= hm_s2_r;
        end
    end

    assign home_evt = hm_s2_r ^ hm_s3_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pat_r <= HOME_PAT_DEF;
        end else if (encoder_home_pattern_command) begin
            pat_r <= home_pattern;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            armed_r <= 1'b0;
            homing_dir_r <= 1'b0;
            home_found_r <= 1'b0;
            stop_decel_r <= 1'b0;
            stop_now_r <= 1'b0;
        end else begin
            if (home_evt) begin
                armed_r <= 1'b0;
                home_found_r <= 1'b1;
                stop_now_r <= home_cfg.stop_abrupt;
                stop_decel_r <= ~home_cfg.stop_abrupt;
            end else if (home_arm) begin
                armed_r <= 1'b1;
                homing_dir_r <= home_cfg.dir_positive;
                home_found_r <= 1'b0;
                stop_decel_r <= 1'b0;
                stop_now_r <= 1'b0;
            end
        end
    end

    assign err = $signed(commanded_pos - fb_position_r);
    assign err_mag = err[POS_W-1] ? POS_W'(-err) : POS_W'(err);
    assign track_prod = $signed(fb_position_r) * gear_num;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            fb_position_r <= '0;
            position_error_r <= '0;
            correction_req_r <= 1'b0;
            stall_r <= 1'b0;
            track_target_r <= '0;
        end else begin
            if (select_absolute_feedback_command) begin
                fb_position_r <= ssi_word_r;
            end else if (fb_mode == FB_OPEN_STEP) begin
                fb_position_r <= commanded_pos;
            end else begin
                fb_position_r <= enc_pos_r;
            end
            position_error_r <= err;
            correction_req_r <= (fb_mode == FB_STEP_ENC) & move_done
                & (err != '0);
            stall_r <= (fb_mode != FB_OPEN_STEP
                || select_absolute_feedback_command)
                && (err_mag > POS_W'(stall_limit));
            if (track_enable) begin
                track_target_r <= POS_W'(track_prod >>> gear_shift);
            end
        end
    end

    // Absolute serial readout
    efh_ssi_state_t ssi_st_r;
    logic [CNT_W-1:0] ssi_cnt_r, ssi_per_r;
    logic [BITS_W-1:0] ssi_left_r;
    logic [SEL_W-1:0] ssi_sel_r;
    logic ssi_wide_r, sd_s1_r, sd_s2_r, ssi_done_r, ssi_start;
    logic [POS_W-1:0] ssi_sh_r;

    assign ssi_start = read_encoder_command & select_absolute_feedback_command
        & (ssi_st_r == SSI_IDLE);
    assign ssi_clk_out = (ssi_st_r != SSI_LOW);
    assign ssi_clk_out_n = ~ssi_clk_out;
    assign ssi_busy = (ssi_st_r != SSI_IDLE);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sd_s1_r <= 1'b0;
            sd_s2_r <= 1'b0;
        end else begin
            sd_s1_r <= ssi_data_in;
            sd_s2_r <= sd_s1_r;
        end
    end

    // Clock depends only on rate and width, so equal axes stay in step
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ssi_st_r <= SSI_IDLE;
            ssi_cnt_r <= '0;
            ssi_per_r <= '0;
            ssi_left_r <= '0;
            ssi_sel_r <= '0;
            ssi_wide_r <= 1'b0;
            ssi_sh_r <= '0;
            ssi_word_r <= '0;
            ssi_done_r <= 1'b0;
        end else begin
            ssi_done_r <= 1'b0;
            case (ssi_st_r)
                SSI_IDLE: begin
                    if (ssi_start) begin
                        ssi_per_r <= ssi_period(
                            absolute_encoder_config_command.rate_sel);
                        ssi_cnt_r <= (ssi_period(
                            absolute_encoder_config_command.rate_sel) >> 1)
                            - CNT_W'(1);
                        ssi_sel_r <= absolute_encoder_config_command.rate_sel;
                        ssi_wide_r <= absolute_encoder_config_command.wide_option;
                        ssi_left_r <= ssi_width(
                            absolute_encoder_config_command.bits,
                            absolute_encoder_config_command.wide_option);
                        ssi_sh_r <= '0;
                        ssi_st_r <= SSI_LOW;
                    end
                end
                SSI_LOW: begin
                    if (ssi_cnt_r == '0) begin
                        ssi_cnt_r <= ssi_per_r - (ssi_per_r >> 1) - CNT_W'(1);
                        ssi_st_r <= SSI_HIGH;
                    end else begin
                        ssi_cnt_r <= ssi_cnt_r - CNT_W'(1);
                    end
                end
                SSI_HIGH: begin
                    if (ssi_cnt_r == '0) begin
                        ssi_sh_r <= {ssi_sh_r[POS_W-2:0], sd_s2_r};
                        if (ssi_left_r == BITS_W'(1)) begin
                            ssi_cnt_r <= CNT_W'(ssi_per_r * SSI_GAP_PERIODS)
                                - CNT_W'(1);
                            ssi_st_r <= SSI_GAP;
                        end else begin
                            ssi_left_r <= ssi_left_r - BITS_W'(1);
                            ssi_cnt_r <= (ssi_per_r >> 1) - CNT_W'(1);
                            ssi_st_r <= SSI_LOW;
                        end
                    end else begin
                        ssi_cnt_r <= ssi_cnt_r - CNT_W'(1);
                    end
                end
                SSI_GAP: begin
                    if (ssi_cnt_r == '0) begin
                        ssi_word_r <= ssi_sh_r;
                        ssi_done_r <= 1'b1;
                        ssi_st_r <= SSI_IDLE;
                    end else begin
                        ssi_cnt_r <= ssi_cnt_r - CNT_W'(1);
                    end
                end
                default: ssi_st_r <= SSI_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            position_r <= '0;
            position_valid_r <= 1'b0;
        end else begin
            position_valid_r <= 1'b0;
            if (ssi_done_r) begin
                position_r <= ssi_sh_r;
                position_valid_r <= 1'b1;
            end else if (read_encoder_command
                && !select_absolute_feedback_command) begin
                position_r <= enc_pos_r;
                position_valid_r <= 1'b1;
            end
        end
    end

    a_quad_count_up:
    assert property (@(posedge enc_clk) disable iff (!enc_rst_n_r)
        quad_up && !home_load |=> pos_r == $past(pos_r) + POS_W'(1))
        else $error("Position did not step up on a quadrature edge");
    a_quad_both_ignored:
    assert property (@(posedge enc_clk) disable iff (!enc_rst_n_r)
        a_chg && b_chg && !home_load |=> $stable(pos_r))
        else $error("Double phase change was counted");
    a_home_preset_load:
    assert property (@(posedge enc_clk) disable iff (!enc_rst_n_r)
        home_load |=> pos_r == $past(ecfg_r.preset))
        else $error("Home event did not load the preset");
    a_enc_home_pattern:
    assert property (@(posedge enc_clk) disable iff (!enc_rst_n_r)
        home_load && ecfg_r.mode == ENCODER_HOMING_MODE |->
        pin_s2_r.index && sw_act && pat_ok)
        else $error("Encoder home declared without all conditions");
    a_pattern_default:
    assert property (@(posedge clk) disable iff (!resetn)
        $rose(resetn) |-> pat_r == HOME_PAT_DEF)
        else $error("Home pattern not at default after reset");
    a_stop_response:
    assert property (@(posedge clk) disable iff (!resetn)
        home_evt |=> stop_now_r == $past(home_cfg.stop_abrupt)
        && stop_decel_r != stop_now_r && home_found_r)
        else $error("Wrong stop response after home event");
    a_home_arm_dir:
    assert property (@(posedge clk) disable iff (!resetn)
        home_arm && !home_evt |=> homing_dir_r == $past(home_cfg.dir_positive)
        && !home_found_r ##1 armed_r || home_found_r)
        else $error("Homing arm did not set direction");
    a_step_correction:
    assert property (@(posedge clk) disable iff (!resetn)
        fb_mode == FB_STEP_ENC && move_done && err != '0 |=>
        correction_req_r && position_error_r == $past(err))
        else $error("Stepper error not flagged after move");
    a_stall_flag:
    assert property (@(posedge clk) disable iff (!resetn)
        fb_mode != FB_OPEN_STEP && err_mag > POS_W'(stall_limit) |=> stall_r)
        else $error("Stall not flagged");
    a_ssi_idle_high:
    assert property (@(posedge clk) disable iff (!resetn)
        ssi_st_r == SSI_IDLE |-> ssi_clk_out && !ssi_clk_out_n)
        else $error("Serial clock not idle high");
    a_ssi_fast_low:
    assert property (@(posedge clk) disable iff (!resetn)
        $fell(ssi_clk_out) && ssi_sel_r == 3'h7 |->
        !ssi_clk_out [*2] ##1 ssi_clk_out [*3])
        else $error("4 MHz serial clock has wrong shape");
    a_ssi_width_cap:
    assert property (@(posedge clk) disable iff (!resetn)
        ssi_st_r != SSI_IDLE |-> ssi_left_r <= (ssi_wide_r ?
        BITS_W'(SSI_MAX_BITS) : BITS_W'(SSI_STD_BITS)))
        else $error("Serial word longer than allowed");
endmodule : efh_axis

// ==== shared/efh_pkg.sv ====
// Constants and types for the axis encoder feedback block
package efh_pkg;
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int SSI_BASE_HZ = 31_250;
    localparam int SSI_STD_BITS = 12;
    localparam int SSI_MAX_BITS = 32;
    localparam int SSI_GAP_PERIODS = 2;
    localparam int POS_W = 32;
    localparam int STALL_W = 16;
    localparam int GEAR_W = 16;
    localparam int GSH_W = 4;
    localparam int SEL_W = 3;
    localparam int BITS_W = 6;
    localparam int CNT_W = 11;

    typedef enum logic [1:0] {
        FB_OPEN_STEP = 2'h0,
        FB_SERVO = 2'h1,
        FB_STEP_ENC = 2'h2
    } efh_fb_mode_t;

    typedef enum logic [1:0] {
        HM_OFF = 2'h0,
        HM_SWITCH = 2'h1,
        ENCODER_HOMING_MODE = 2'h2
    } efh_home_mode_t;

    typedef enum logic [1:0] {
        SSI_IDLE = 2'h0,
        SSI_LOW = 2'h1,
        SSI_HIGH = 2'h3,
        SSI_GAP = 2'h2
    } efh_ssi_state_t;

    typedef struct packed {
        logic a;
        logic b;
        logic index;
        logic home_sw;
    } efh_enc_pins_t;

    typedef struct packed {
        logic req_a;
        logic req_b;
        logic care_a;
        logic care_b;
    } efh_home_pat_t;

    typedef struct packed {
        efh_home_mode_t mode;
        logic sw_active_high;
        logic dir_positive;
        logic stop_abrupt;
        logic [POS_W-1:0] preset;
    } efh_home_cfg_t;

    typedef struct packed {
        efh_home_mode_t mode;
        logic sw_active_high;
        efh_home_pat_t pat;
        logic armed;
        logic [POS_W-1:0] preset;
    } efh_enc_cfg_t;

    typedef struct packed {
        logic [SEL_W-1:0] rate_sel;
        logic [BITS_W-1:0] bits;
        logic wide_option;
    } efh_ssi_cfg_t;

    localparam efh_home_pat_t HOME_PAT_DEF = '{
        req_a: 1'h1, req_b: 1'h0, care_a: 1'h1, care_b: 1'h1};
endpackage : efh_pkg

// ==== testbench/efh_enc_model.sv ====
// Quadrature encoder, home switch and serial absolute encoder model
module efh_enc_model
    import efh_pkg::*;
(
    output efh_enc_pins_t pins,
    input wire logic abs_mode,
    input wire logic ssi_clk,
    input wire logic [31:0] ssi_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic qa = 1'b0, qb = 1'b0, sdat = 1'b1, idx = 1'b0, sw = 1'b0;
    time t_rise = 0, t_fall = 0, low_len = 0;
    int k = 0, edges = 0;
    // Serial data leaves on the phase A line in absolute mode
    assign pins = '{a: abs_mode ? sdat : qa, b: qb, index: idx, home_sw: sw};
    // One phase moves per step, A leads B when counting up
    task automatic step(input bit up);
        if (qa ^ qb ^ up) qa = ~qa;
        else qb = ~qb;
        #200;
    endtask : step
    task automatic both();
        qa = ~qa;
        qb = ~qb;
        #200;
    endtask : both
    // Long high time on the clock releases the line to a flipping level
    always @(posedge ssi_clk) begin
        t_rise = $time;
        low_len = t_rise - t_fall;
        edges++;
        fork
            automatic int n = edges;
            #(3 * low_len) if (ssi_clk && n == edges) sdat = ~sdat;
        join_none
    end
    // New word after a gap, MSB first on each falling clock edge
    always @(negedge ssi_clk) begin
        if ($time - t_rise > 3 * low_len) k = 31;
        else k = k - 1;
        t_fall = $time;
        edges++;
        sdat = (k >= 0) ? ssi_word[k] : ~sdat;
    end
endmodule : efh_enc_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the axis encoder feedback block
module tb_top import efh_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, resetn = 0, enc_clk = 0, abs_sel = 0, pat_cmd = 0;
    logic home_arm = 0, move_done = 0, track_en = 0, rd = 0;
    efh_fb_mode_t fb_mode = FB_SERVO;
    efh_home_cfg_t home_cfg = '0;
    efh_home_pat_t home_pat = HOME_PAT_DEF;
    efh_ssi_cfg_t ssi_cfg = '0;
    efh_enc_pins_t pins;
    logic [POS_W-1:0] cmd_pos = '0, pos, fbp, perr, trk;
    logic [STALL_W-1:0] stall_lim = '0;
    logic signed [GEAR_W-1:0] gear_num = '0;
    logic [GSH_W-1:0] gear_sh = '0;
    logic [31:0] ssi_word = '0;
    logic sclk, sclk_n, pos_v, corr, stall, hdir, hfound, sdec, snow, busy;
    logic [31:0] expq[$];
    int err_total = 0, tests_run = 0, cycles = 0, expc = 0, preset = 0;
    integer seed = 32'h4194_8aa4;
    efh_enc_model u_enc (.pins(pins), .abs_mode(abs_sel), .ssi_clk(sclk),
        .ssi_word(ssi_word));
    efh_axis DUT (.clk(clk), .resetn(resetn), .enc_clk(enc_clk),
        .enc_pins(pins), .fb_mode(fb_mode),
        .select_absolute_feedback_command(abs_sel), .home_cfg(home_cfg),
        .encoder_home_pattern_command(pat_cmd), .home_pattern(home_pat),
        .home_arm(home_arm), .commanded_pos(cmd_pos), .move_done(move_done),
        .stall_limit(stall_lim), .track_enable(track_en),
        .gear_num(gear_num), .gear_shift(gear_sh),
        .absolute_encoder_config_command(ssi_cfg),
        .read_encoder_command(rd), .ssi_data_in(pins.a),
        .ssi_clk_out(sclk), .ssi_clk_out_n(sclk_n), .position_r(pos),
        .position_valid_r(pos_v), .fb_position_r(fbp),
        .position_error_r(perr), .correction_req_r(corr), .stall_r(stall),
        .track_target_r(trk), .homing_dir_r(hdir), .home_found_r(hfound),
        .stop_decel_r(sdec), .stop_now_r(snow), .ssi_busy(busy));
    initial forever #25 clk = ~clk;
    initial begin
        #13;
        forever #40 enc_clk = ~enc_clk;
    end
    task automatic finish_test();
        if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_val
    task automatic cmp_pos(input logic [31:0] got);
        tests_run++;
        if (expq.size() == 0 || got !== expq[0]) begin
            err_total++;
            $display("ERROR %0t unexpected position %h", $time, got);
        end
        if (expq.size() > 0) void'(expq.pop_front());
    endtask : cmp_pos
    always @(posedge clk) if (pos_v === 1'b1) cmp_pos(pos);
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic rd_pos(input logic [31:0] exp);
        expq.push_back(exp);
        rd = 1;
        tick();
        rd = 0;
        tick(2);
    endtask : rd_pos
    task automatic move(input int n, input bit up);
        repeat (n) begin
            u_enc.step(up);
            expc += up ? 1 : -1;
        end
        tick(20);
    endtask : move
    task automatic arm();
        home_arm = 1;
        tick();
        home_arm = 0;
        tick(10);
    endtask : arm
    task automatic ssi_read(input int sel, nb, wide, n);
        int p;
        time t0;
        p = SYS_CLK_HZ / (SSI_BASE_HZ << sel);
        ssi_word = $random(seed);
        ssi_cfg = '{rate_sel: sel[2:0], bits: nb[5:0], wide_option: wide[0]};
        expq.push_back(ssi_word >> (32 - n));
        rd = 1;
        tick();
        cmp_val(busy, 1);
        tick();
        rd = 0;
        cmp_val({sclk ^ sclk_n}, 1);
        if (n > 1) begin
            @(negedge sclk) t0 = $time;
            @(negedge sclk) cmp_val(32'($time - t0), 32'(p * 50));
        end
        for (int i = 0; i < (n + 4) * p && busy !== 1'b0; i++) tick();
        tick(3);
        cmp_val(fbp, ssi_word >> (32 - n));
    endtask : ssi_read
    initial begin
        tick(3);
        cmp_val(sclk, 1);
        resetn = 1;
        tick(6);
        move(5 + ($unsigned($random(seed)) % 16), 1);
        move(3, 0);
        rd_pos(expc);
        u_enc.both();
        tick(20);
        rd_pos(expc);
        expq.push_back(expc);
        expq.push_back(expc);
        rd = 1;
        tick(2);
        rd = 0;
        tick(2);
        for (int s = 0; s < 2; s++) begin
            preset = $random(seed) & 32'h0000_ffff;
            home_cfg = '{mode: HM_SWITCH, sw_active_high: s[0],
                dir_positive: s[0], stop_abrupt: s[0], preset: preset};
            u_enc.sw = ~s[0];
            arm();
            cmp_val(hdir, 32'(s));
            cmp_val(hfound, 0);
            u_enc.sw = s[0];
            tick(20);
            cmp_val(hfound, 1);
            cmp_val(snow, 32'(s));
            cmp_val(sdec, 32'(s == 0));
            expc = preset;
            move(2, 1);
            u_enc.sw = ~s[0];
            tick(10);
            u_enc.sw = s[0];
            tick(20);
            rd_pos(expc);
            u_enc.sw = 0;
        end
        home_cfg.mode = ENCODER_HOMING_MODE;
        repeat (4) if (!(u_enc.qa && u_enc.qb)) move(1, 1);
        arm();
        u_enc.sw = 1;
        u_enc.idx = 1;
        tick(20);
        cmp_val(hfound, 0);
        u_enc.idx = 0;
        move(1, 0);
        u_enc.idx = 1;
        tick(20);
        cmp_val(hfound, 1);
        expc = preset;
        rd_pos(expc);
        home_pat = '{req_a: 1'b0, req_b: 1'b1, care_a: 1'b0, care_b: 1'b1};
        pat_cmd = 1;
        tick();
        pat_cmd = 0;
        u_enc.idx = 0;
        arm();
        u_enc.idx = 1;
        tick(20);
        cmp_val(hfound, 0);
        u_enc.idx = 0;
        move(1, 1);
        u_enc.idx = 1;
        tick(20);
        cmp_val(hfound, 1);
        expc = preset;
        fb_mode = FB_STEP_ENC;
        cmd_pos = expc + 5;
        stall_lim = 4;
        move_done = 1;
        track_en = 1;
        gear_num = 3;
        gear_sh = 1;
        tick(6);
        cmp_val(fbp, expc);
        cmp_val(perr, 5);
        cmp_val(corr, 1);
        cmp_val(stall, 1);
        cmp_val(trk, (expc * 3) >>> 1);
        stall_lim = 5;
        tick(4);
        cmp_val(stall, 0);
        fb_mode = FB_OPEN_STEP;
        cmd_pos = $random(seed);
        tick(4);
        cmp_val(fbp, cmd_pos);
        abs_sel = 1;
        ssi_read(7, 12, 0, 12);
        ssi_read(6, 20, 0, 12);
        ssi_read(7, 32, 1, 32);
        ssi_read(5, 0, 0, 1);
        ssi_read(0, 3, 0, 3);
        cmp_val(expq.size(), 0);
        finish_test();
    end
endmodule : tb_top
